// >>> include/status_led_params.svh
`ifndef STATUS_LED_PARAMS_SVH
`define STATUS_LED_PARAMS_SVH
`define CLK_HZ          25000000
`define TICK_MS         1
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)
`define SHORT_MS        500
`define LONG_MS         2500
`define PERIOD_MS       3000
`define ACT_ON_MS       50
`define ACT_OFF_MS      50
`endif

// >>> include/status_led_pkg.sv
package status_led_pkg;
   typedef enum logic [3:0] {
      MODE_PRIMARY = 4'h1,
      MODE_STANDBY = 4'h2,
      MODE_OFFLINE = 4'h4,
      MODE_STOPPED = 4'h8
   } run_mode_t;
   typedef enum logic [2:0] {
      ACT_IDLE  = 3'h1,
      ACT_ON    = 3'h2,
      ACT_OFF   = 3'h4
   } act_state_t;
endpackage

// >>> design/activity_stretcher.sv
`timescale 1ns/10ps
`default_nettype none
`include "status_led_params.svh"
module activity_stretcher #(
   parameter int ON_MS  = `ACT_ON_MS,
   parameter int OFF_MS = `ACT_OFF_MS
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic tick_ms,
   input  wire logic traffic,
   output logic      led
);
   import status_led_pkg::*;

   act_state_t  state_reg;
   logic [15:0] cnt_reg;
   logic        pend_reg;

   // ------------------------------------------------------------
   // pending event: traffic seen while a blink is under way
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pend_reg <= 1'b0;
      end else if (state_reg == ACT_IDLE || (state_reg == ACT_OFF && tick_ms &&
                   cnt_reg == 16'h0000)) begin
         // a blink may start here and uses traffic directly, so one event is one blink
         pend_reg <= 1'b0;
      end else if (traffic) begin
         pend_reg <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // blink sequencer: on/off cycles repeat while traffic continues
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ACT_IDLE;
         cnt_reg   <= 16'h0000;
      end else begin
         unique case (state_reg)
            ACT_IDLE: begin
               if (pend_reg || traffic) begin
                  state_reg <= ACT_ON;
                  cnt_reg   <= 16'(ON_MS - 1);
               end
            end
            ACT_ON: begin
               if (tick_ms) begin
                  if (cnt_reg == 16'h0000) begin
                     state_reg <= ACT_OFF;
                     cnt_reg   <= 16'(OFF_MS - 1);
                  end else begin
                     cnt_reg <= cnt_reg - 16'h0001;
                  end
               end
            end
            ACT_OFF: begin
               // retrigger: pending or new traffic starts the next blink when the off count ends; the repeat rate stays ON_MS + OFF_MS
               if (tick_ms) begin
                  if (cnt_reg == 16'h0000) begin
                     state_reg <= (pend_reg || traffic) ? ACT_ON : ACT_IDLE;
                     cnt_reg   <= 16'(ON_MS - 1);
                  end else begin
                     cnt_reg <= cnt_reg - 16'h0001;
                  end
               end
            end
         endcase
      end
   end

   assign led = (state_reg == ACT_ON);
endmodule
`default_nettype wire

// >>> design/status_led_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "status_led_params.svh"
module status_led_controller #(
   parameter int  TICK_CYCLES  = `TICK_CYCLES,
   parameter bit  REDUNDANT    = 1'b0,
   parameter bit  HAS_FIELDBUS = 1'b1
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic running,
   input  wire logic stop_req,
   input  wire logic run_req,
   input  wire logic sw_fault_halt,
   input  wire logic configured,
   input  wire logic role_primary,
   input  wire logic role_standby,
   input  wire logic processor_fault,
   input  wire logic system_fault,
   input  wire logic card_battery_weak,
   input  wire logic backplane_fault,
   input  wire logic io_module_fault,
   input  wire logic io_channel_fault,
   input  wire logic io_config_fault,
   input  wire logic card_inserted,
   input  wire logic card_auto_run,
   input  wire logic terminal_traffic,
   input  wire logic fieldbus_traffic,
   output logic      run_led,
   output logic      error_led,
   output logic      io_error_led,
   output logic      terminal_link_indicator,
   output logic      fieldbus_link_indicator,
   output logic      run_state
);
   import status_led_pkg::*;

   logic [24:0] pre_reg;
   logic        tick_ms;
   logic [11:0] phase_reg;
   logic        slow_reg;
   logic [9:0]  half_reg;
   logic        card_prev_reg;
   logic        run_state_reg;
   logic        run_led_reg;
   logic        error_led_reg;
   logic        io_led_reg;
   logic        term_led;
   logic        field_led;
   run_mode_t   mode;

   // ------------------------------------------------------------
   // millisecond prescaler
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pre_reg <= 25'h0000000;
      end else if (pre_reg == 25'(TICK_CYCLES - 1)) begin
         pre_reg <= 25'h0000000;
      end else begin
         pre_reg <= pre_reg + 25'h0000001;
      end
   end
   assign tick_ms = (pre_reg == 25'(TICK_CYCLES - 1));

   // ------------------------------------------------------------
   // 3 s pattern phase and 500 ms symmetric flasher
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phase_reg <= 12'h000;
      end else if (tick_ms) begin
         phase_reg <= (phase_reg == 12'(`PERIOD_MS - 1)) ? 12'h000 : phase_reg + 12'h001;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         half_reg <= 10'h000;
         slow_reg <= 1'b1;
      end else if (tick_ms) begin
         if (half_reg == 10'(`SHORT_MS - 1)) begin
            half_reg <= 10'h000;
            slow_reg <= ~slow_reg;
         end else begin
            half_reg <= half_reg + 10'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // run state, with auto run on card insertion
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         card_prev_reg <= 1'b0;
      end else begin
         card_prev_reg <= card_inserted;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         run_state_reg <= 1'b0;
      end else if (!configured || sw_fault_halt) begin
         run_state_reg <= 1'b0;
      end else if (card_inserted && !card_prev_reg && card_auto_run) begin
         run_state_reg <= 1'b1;
      end else if (stop_req) begin
         run_state_reg <= 1'b0;
      end else if (run_req) begin
         run_state_reg <= 1'b1;
      end
   end
   assign run_state = run_state_reg;

   // ------------------------------------------------------------
   // run indicator
   // ------------------------------------------------------------
   always_comb begin
      if (!running || sw_fault_halt) begin
         mode = MODE_STOPPED;
      end else if (!REDUNDANT || role_primary) begin
         mode = MODE_PRIMARY;
      end else if (role_standby) begin
         mode = MODE_STANDBY;
      end else begin
         mode = MODE_OFFLINE;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         run_led_reg <= 1'b0;
      end else if (!configured) begin
         run_led_reg <= 1'b0;
      end else begin
         unique case (mode)
            MODE_PRIMARY: run_led_reg <= 1'b1;
            MODE_STANDBY: run_led_reg <= (phase_reg < 12'(`LONG_MS));
            MODE_OFFLINE: run_led_reg <= (phase_reg < 12'(`SHORT_MS));
            MODE_STOPPED: run_led_reg <= slow_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // error and io error indicators
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         error_led_reg <= 1'b0;
      end else if (processor_fault || system_fault) begin
         error_led_reg <= 1'b1;
      end else if (!configured || sw_fault_halt || card_battery_weak || backplane_fault) begin
         error_led_reg <= slow_reg;
      end else begin
         error_led_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         io_led_reg <= 1'b0;
      end else if (io_module_fault || io_channel_fault || io_config_fault) begin
         io_led_reg <= 1'b1;
      end else if (backplane_fault) begin
         io_led_reg <= slow_reg;
      end else begin
         io_led_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // link activity indicators
   // ------------------------------------------------------------
   activity_stretcher u_term (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .tick_ms (tick_ms),
      .traffic (terminal_traffic),
      .led     (term_led)
   );

   generate
      if (HAS_FIELDBUS) begin : g_field
         activity_stretcher u_field (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .tick_ms (tick_ms),
            .traffic (fieldbus_traffic),
            .led     (field_led)
         );
      end else begin : g_nofield
         assign field_led = 1'b0;
      end
   endgenerate

   assign run_led                 = run_led_reg;
   assign error_led               = error_led_reg;
   assign io_error_led            = io_led_reg;
   assign terminal_link_indicator = term_led;
   assign fieldbus_link_indicator = field_led;
endmodule
`default_nettype wire

// >>> tb/led_viewer.sv
`timescale 1ns/10ps
`default_nettype none
module led_viewer (
   input  wire logic   clk_sys,
   input  wire logic   led,
   input  wire logic   window,
   output logic [31:0] lit_cnt
);
   logic window_reg;
   // operator's eye: counts lit cycles while the window is open
   always_ff @(posedge clk_sys) begin
      window_reg <= window;
      if (window && !window_reg)
         lit_cnt <= 32'(led);
      else if (window && led)
         lit_cnt <= lit_cnt + 1;
   end
endmodule
`default_nettype wire

// >>> tb/status_led_checker.sv
`timescale 1ns/10ps
`default_nettype none
module status_led_checker #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic configured,
   input wire logic sw_fault_halt,
   input wire logic stop_req,
   input wire logic processor_fault,
   input wire logic system_fault,
   input wire logic card_battery_weak,
   input wire logic backplane_fault,
   input wire logic io_module_fault,
   input wire logic io_channel_fault,
   input wire logic io_config_fault,
   input wire logic card_inserted,
   input wire logic card_auto_run,
   input wire logic terminal_traffic,
   input wire logic run_led,
   input wire logic error_led,
   input wire logic io_error_led,
   input wire logic terminal_link_indicator,
   input wire logic run_state
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [31:0] on_reg;
   logic [31:0] idle_reg;
   wire io_f = io_module_fault || io_channel_fault || io_config_fault;
   wire hard_f = processor_fault || system_fault;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         on_reg   <= '0;
         idle_reg <= '0;
      end else begin
         on_reg   <= terminal_link_indicator ? on_reg + 1 : '0;
         idle_reg <= terminal_traffic ? '0 : idle_reg + 1;
      end
   end
   unconf_dark_a: assert property (!configured [*2] |-> !run_led)
      else $error("run lamp lit while unconfigured");
   err_steady_a: assert property (hard_f [*2] |-> error_led)
      else $error("error lamp not steady on fault");
   io_steady_a: assert property (io_f [*2] |-> io_error_led)
      else $error("io lamp not steady on io fault");
   err_dark_a: assert property ((configured && !sw_fault_halt && !hard_f
      && !card_battery_weak && !backplane_fault) [*2] |-> !error_led)
      else $error("error lamp lit with no fault");
   io_dark_a: assert property (!(io_f || backplane_fault) [*2] |-> !io_error_led)
      else $error("io lamp lit with no fault");
   bus_phase_a: assert property ((backplane_fault && !hard_f && !io_f) [*2]
      |-> error_led == io_error_led)
      else $error("bus fault lamps out of phase");
   never_steady_a: assert property (on_reg <= 51 * TICK_CYCLES)
      else $error("terminal lamp lit too long");
   idle_dark_a: assert property (idle_reg > 160 * TICK_CYCLES |-> !terminal_link_indicator)
      else $error("terminal lamp lit without traffic");
   auto_run_a: assert property ($rose(card_inserted) && card_auto_run && configured
      && !sw_fault_halt && !stop_req |-> ##[1:2] run_state)
      else $error("no automatic run after card insertion");
endmodule
bind status_led_controller status_led_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);
`default_nettype wire

// >>> tb/status_led_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
module status_led_controller_tb;
   localparam int TK = 4;
   localparam int W = 1000 * TK;
   logic clk_sys = 0, resetn = 0, running = 0, stop_req = 0, run_req = 0, window = 0;
   logic role_primary = 0, role_standby = 0, card_inserted = 0, card_auto_run = 0;
   logic run_led, error_led, io_error_led, terminal_link_indicator, fieldbus_link_indicator;
   logic run_state, run2, fb2;
   logic [8:0] flt = '0;
   logic [1:0] trf = '0;
   logic [31:0] lit [7];
   int bad_count = 0, num_checks = 0, cyc = 0;
   wire processor_fault = flt[0], system_fault = flt[1], card_battery_weak = flt[2],
        backplane_fault = flt[3], io_module_fault = flt[4], io_channel_fault = flt[5],
        io_config_fault = flt[6], sw_fault_halt = flt[7], configured = ~flt[8];
   wire terminal_traffic = trf[0], fieldbus_traffic = trf[1];
   wire [6:0] lamp = {fb2, run2, fieldbus_link_indicator, terminal_link_indicator,
                      io_error_led, error_led, run_led};
   status_led_controller #(.TICK_CYCLES(TK), .REDUNDANT(1'b0), .HAS_FIELDBUS(1'b1)) dut (.*);
   // second unit: redundant variant without the fieldbus indicator fitted
   status_led_controller #(.TICK_CYCLES(TK), .REDUNDANT(1'b1), .HAS_FIELDBUS(1'b0)) dut2 (
      .*, .run_led(run2), .error_led(), .io_error_led(), .terminal_link_indicator(),
      .fieldbus_link_indicator(fb2), .run_state());
   for (genvar i = 0; i < 7; i++) begin : g_view
      led_viewer v (.clk_sys(clk_sys), .led(lamp[i]), .window(window), .lit_cnt(lit[i]));
   end
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         bad_count++;
         finish_test;
      end
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got, int tol);
      num_checks++;
      if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
         bad_count++;
         $display("FAIL %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   task automatic meas(int n);
      repeat (200) @(posedge clk_sys);
      window <= 1;
      repeat (n) @(posedge clk_sys);
      window <= 0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic go(logic stby);
      @(posedge clk_sys);
      run_req <= 1;
      running <= 1;
      role_primary <= !stby;
      role_standby <= stby;
      @(posedge clk_sys);
      run_req <= 0;
   endtask
   task automatic t_run;
      go(0);
      meas(W);
      chk("run_led", W, lit[0], 0);
      chk("run_led_red", W, lit[5], 0);
      chk("error_led", 0, lit[1], 0);
      chk("io_error_led", 0, lit[2], 0);
      chk("link_dark", 0, lit[3] + lit[4], 0);
   endtask
   task automatic t_stop;
      @(posedge clk_sys);
      stop_req <= 1;
      running <= 0;
      @(posedge clk_sys);
      stop_req <= 0;
      meas(W);
      chk("run_led", W / 2, lit[0], 2 * TK);
      chk("run_led_red", W / 2, lit[5], 2 * TK);
      chk("run_state", 0, run_state, 0);
   endtask
   task automatic t_roles;
      go(1);
      meas(3 * W);
      chk("run_standby", 2500 * TK, lit[5], 2 * TK);
      chk("run_led", 3 * W, lit[0], 0);
      @(posedge clk_sys);
      role_standby <= 0;
      meas(3 * W);
      chk("run_offline", 500 * TK, lit[5], 2 * TK);
   endtask
   task automatic t_faults;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         flt <= (i == 9) ? 9'h005 : 9'h001 << i;
         meas(W);
         chk("error_led", (i < 2 || i == 9) ? W : ((i == 2 || i == 3 || i > 6) ? W / 2 : 0),
             lit[1], 2 * TK);
         chk("io_error_led", (i > 3 && i < 7) ? W : ((i == 3) ? W / 2 : 0),
             lit[2], 2 * TK);
         if (i == 8)
            chk("run_unconf", 0, lit[0] + lit[5], 0);
      end
      @(posedge clk_sys);
      flt <= '0;
   endtask
   task automatic blink(int i, int n, int gap, int exp);
      @(posedge clk_sys);
      window <= 1;
      repeat (n) begin
         trf[i] <= 1;
         @(posedge clk_sys);
         trf[i] <= 0;
         repeat (gap) @(posedge clk_sys);
      end
      window <= 0;
      @(posedge clk_sys);
      #1;
      chk("link_lit", exp, lit[3 + i], 4 * TK);
      if (i == 1)
         chk("link_absent", 0, lit[6], 0);
   endtask
   task automatic t_auto;
      @(posedge clk_sys);
      card_auto_run <= 1;
      @(posedge clk_sys);
      card_inserted <= 1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("run_state", 1, run_state, 0);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1;
      t_run;
      t_stop;
      t_roles;
      t_faults;
      for (int i = 0; i < 2; i++) begin
         blink(i, 1, 200 * TK - 1, 50 * TK);
         blink(i, 100, 15, 200 * TK);
      end
      t_auto;
      finish_test;
   end
endmodule
`default_nettype wire
